//--- logic/drdma_cfg.svh
`ifndef DRDMA_CFG_SVH
`define DRDMA_CFG_SVH
`define DRDMA_CLK_PERIOD_NS 20
`define DRDMA_WINDOW_NS 1000000000
`define DRDMA_DESC_STRIDE 32'h00000020
`define DRDMA_PTR_RST 32'h00000000
`define DRDMA_SEL_ENG_NEXT 3'h0
`define DRDMA_SEL_SOFTWARE_NEXT_DESC_POINTER 3'h1
`define DRDMA_SEL_COMPLETED 3'h2
`define DRDMA_SEL_RING_BASE 3'h3
`define DRDMA_SEL_RING_LAST 3'h4
`define DRDMA_ST_DONE 0
`define DRDMA_ST_ERR 1
`define DRDMA_ST_SHORT 2
`define DRDMA_ST_START 3
`define DRDMA_ST_END 4
`define DRDMA_ST_USER_LSB 8
`define DRDMA_ST_USER_MSB 15
`define DRDMA_ST_LEN_LSB 16
`define DRDMA_ST_LEN_MSB 31
`endif

//--- logic/drdma_pkg.sv
`default_nettype none
package drdma_pkg;
   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_FETCH = 4'h2,
      ST_XFER  = 4'h4,
      ST_WBACK = 4'h8
   } drdma_state_t;
endpackage : drdma_pkg
`default_nettype wire

//--- logic/drdma_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "drdma_cfg.svh"
module drdma_ctrl
   import drdma_pkg::*;
#(
   parameter int NCH = 4,
   parameter int NTX = 2,
   parameter int AW  = 32,
   parameter int CW  = 8,
   parameter int WINDOW_CYCLES = `DRDMA_WINDOW_NS / `DRDMA_CLK_PERIOD_NS
) (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic [NCH-1:0]         chanEnable,
   input  wire logic                   intEnableWr,
   input  wire logic [NCH-1:0]         intEnableData,
   input  wire logic [CW-1:0]          coalesceN,
   input  wire logic                   ptrWrEn,
   input  wire logic [1:0]             ptrWrChan,
   input  wire logic [2:0]             ptrWrSel,
   input  wire logic [AW-1:0]          ptrWrData,
   input  wire logic                   descFetchAck,
   input  wire logic [15:0]            descLen,
   input  wire logic                   descStart,
   input  wire logic                   descEnd,
   input  wire logic                   descIrq,
   input  wire logic [7:0]             descUserCtl,
   input  wire logic                   bufDone,
   input  wire logic [15:0]            bufCount,
   input  wire logic                   bufErr,
   input  wire logic                   bufStart,
   input  wire logic                   bufEnd,
   input  wire logic [7:0]             bufUserStatus,
   input  wire logic                   wbReady,
   input  wire logic                   epTxBusy,
   input  wire logic                   epRxBusy,
   output logic [NCH-1:0][AW-1:0]      completedPtr_q,
   output logic [NCH-1:0][AW-1:0]      engNextPtr_q,
   output logic [NCH-1:0][AW-1:0]      swNextPtr_q,
   output logic [NCH-1:0]              intEnabled_q,
   output logic [NCH-1:0]              irqPulse_q,
   output logic                        descFetchReq_q,
   output logic [AW-1:0]               descFetchAddr_q,
   output logic [1:0]                  chan_q,
   output logic                        bufReq_q,
   output logic [15:0]                 bufLen_q,
   output logic                        xferStart_q,
   output logic                        xferEnd_q,
   output logic [7:0]                  xferUserCtl_q,
   output logic                        wbValid_q,
   output logic [AW-1:0]               wbAddr_q,
   output logic [31:0]                 wbStatus_q,
   output logic [NCH-1:0][31:0]        activeNs_q,
   output logic [NCH-1:0][31:0]        waitNs_q,
   output logic [31:0]                 epTxUtil_q,
   output logic [31:0]                 epRxUtil_q
);
   localparam logic [31:0] NS_STEP = 32'(`DRDMA_CLK_PERIOD_NS);

   function automatic logic [AW-1:0] nextDesc(input logic [AW-1:0] a,
                                              input logic [AW-1:0] b,
                                              input logic [AW-1:0] l);
      nextDesc = (a == l) ? b : a + AW'(`DRDMA_DESC_STRIDE);
   endfunction : nextDesc

   function automatic logic [1:0] pickChan(input logic [NCH-1:0] rdy,
                                           input logic [1:0] last);
      logic [1:0] c;
      c = last;
      pickChan = last;
      for (int i = NCH; i >= 1; i--) begin
         c = 2'(int'(last) + i);
         if (rdy[c]) pickChan = c;
      end
   endfunction : pickChan

   drdma_state_t           state_q;
   logic [NCH-1:0][AW-1:0] ringBase_q, ringLast_q;
   logic [NCH-1:0][CW-1:0] coalCnt_q;
   logic [NCH-1:0][31:0]   activeAcc_q, waitAcc_q;
   logic [NCH-1:0]         inPkt_q, ready, swWr, chanBusy, chanWait;
   logic [15:0]            dLen_q;
   logic                   dIrq_q;
   logic [31:0]            stat_q, statWord, winCnt_q, txAcc_q, rxAcc_q;
   logic                   wb1Valid_q;
   logic [AW-1:0]          wb1Addr_q;
   logic [31:0]            wb1Status_q;
   logic                   isTx, shortHit, frameErr, wbPush, wbPop, tick, irqHit;
   logic [CW-1:0]          coalNext;

   for (genvar g = 0; g < NCH; g++) begin : g_dec
      assign ready[g] = chanEnable[g] && (engNextPtr_q[g] != swNextPtr_q[g]);
      assign swWr[g] = ptrWrEn && (ptrWrChan == 2'(g));
      assign chanBusy[g] = (state_q != ST_IDLE) && (chan_q == 2'(g));
      assign chanWait[g] = chanEnable[g] && !ready[g] && !chanBusy[g];
   end

   assign isTx = int'(chan_q) < NTX;
   assign shortHit = isTx && (bufCount < dLen_q);
   assign frameErr = isTx && (inPkt_q[chan_q] == xferStart_q);
   assign wbPush = (state_q == ST_WBACK) && !wb1Valid_q;
   assign wbPop = wbValid_q && wbReady;
   assign tick = winCnt_q == 32'(WINDOW_CYCLES - 1);
   assign coalNext = coalCnt_q[chan_q] + CW'(1);
   assign irqHit = dIrq_q || ((coalesceN != '0) && (coalNext >= coalesceN));

   always_comb begin
      statWord = '0;
      statWord[`DRDMA_ST_DONE] = 1'b1;
      statWord[`DRDMA_ST_ERR] = bufErr || frameErr;
      statWord[`DRDMA_ST_SHORT] = shortHit;
      statWord[`DRDMA_ST_START] = isTx ? xferStart_q : bufStart;
      statWord[`DRDMA_ST_END] = isTx ? xferEnd_q : bufEnd;
      statWord[`DRDMA_ST_USER_MSB:`DRDMA_ST_USER_LSB] = isTx ? 8'h00 : bufUserStatus;
      statWord[`DRDMA_ST_LEN_MSB:`DRDMA_ST_LEN_LSB] = bufCount;
   end

   // Descriptor sequencer shared by all rings; round robin keeps any ring from starving.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
         chan_q <= 2'h0;
         descFetchReq_q <= 1'b0;
         descFetchAddr_q <= '0;
         bufReq_q <= 1'b0;
         bufLen_q <= 16'h0000;
         xferStart_q <= 1'b0;
         xferEnd_q <= 1'b0;
         xferUserCtl_q <= 8'h00;
         dLen_q <= 16'h0000;
         dIrq_q <= 1'b0;
         stat_q <= 32'h00000000;
      end else begin
         case (state_q)
            ST_IDLE: if (|ready) begin
               chan_q <= pickChan(ready, chan_q);
               descFetchAddr_q <= engNextPtr_q[pickChan(ready, chan_q)];
               descFetchReq_q <= 1'b1;
               state_q <= ST_FETCH;
            end
            ST_FETCH: if (descFetchAck) begin
               descFetchReq_q <= 1'b0;
               dLen_q <= descLen;
               dIrq_q <= descIrq;
               bufReq_q <= 1'b1;
               bufLen_q <= descLen;
               xferStart_q <= descStart;
               xferEnd_q <= descEnd;
               xferUserCtl_q <= descUserCtl;
               state_q <= ST_XFER;
            end
            ST_XFER: if (bufDone) begin
               bufReq_q <= 1'b0;
               stat_q <= statWord;
               state_q <= ST_WBACK;
            end
            ST_WBACK: if (wbPush) begin
               state_q <= ST_IDLE;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Software pointer writes come first; the engine only moves its own pointers.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         completedPtr_q <= '0;
         engNextPtr_q <= '0;
         swNextPtr_q <= '0;
         ringBase_q <= '0;
         ringLast_q <= '0;
      end else begin
         for (int c = 0; c < NCH; c++) begin
            if (swWr[c] && ptrWrSel == `DRDMA_SEL_SOFTWARE_NEXT_DESC_POINTER) swNextPtr_q[c] <= ptrWrData;
            if (swWr[c] && ptrWrSel == `DRDMA_SEL_RING_BASE) ringBase_q[c] <= ptrWrData;
            if (swWr[c] && ptrWrSel == `DRDMA_SEL_RING_LAST) ringLast_q[c] <= ptrWrData;
            if (swWr[c] && ptrWrSel == `DRDMA_SEL_ENG_NEXT) begin
               engNextPtr_q[c] <= ptrWrData;
            end else if (wbPush && chan_q == 2'(c)) begin
               engNextPtr_q[c] <= nextDesc(descFetchAddr_q, ringBase_q[c],
                                           ringLast_q[c]);
            end
            if (swWr[c] && ptrWrSel == `DRDMA_SEL_COMPLETED) begin
               completedPtr_q[c] <= AW'(`DRDMA_PTR_RST);
            end else if (wbPush && chan_q == 2'(c)) begin
               completedPtr_q[c] <= descFetchAddr_q;
            end
         end
      end
   end

   // Packet framing, coalescing and interrupt enables.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         inPkt_q <= '0;
         coalCnt_q <= '0;
         irqPulse_q <= '0;
         intEnabled_q <= '0;
      end else begin
         irqPulse_q <= '0;
         if (intEnableWr) intEnabled_q <= intEnableData;
         if (wbPush) begin
            if (isTx) inPkt_q[chan_q] <= !xferEnd_q;
            coalCnt_q[chan_q] <= irqHit ? '0 : coalNext;
            irqPulse_q[chan_q] <= irqHit && intEnabled_q[chan_q];
         end
      end
   end

   // Two-entry writeback buffer; a full buffer holds the sequencer in writeback.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wbValid_q <= 1'b0;
         wbAddr_q <= '0;
         wbStatus_q <= 32'h00000000;
         wb1Valid_q <= 1'b0;
         wb1Addr_q <= '0;
         wb1Status_q <= 32'h00000000;
      end else if (wbPop && (wbPush || !wb1Valid_q)) begin
         wbValid_q <= wbPush;
         wbAddr_q <= descFetchAddr_q;
         wbStatus_q <= stat_q;
      end else if (wbPop) begin
         wbAddr_q <= wb1Addr_q;
         wbStatus_q <= wb1Status_q;
         wb1Valid_q <= 1'b0;
      end else if (wbPush && !wbValid_q) begin
         wbValid_q <= 1'b1;
         wbAddr_q <= descFetchAddr_q;
         wbStatus_q <= stat_q;
      end else if (wbPush) begin
         wb1Valid_q <= 1'b1;
         wb1Addr_q <= descFetchAddr_q;
         wb1Status_q <= stat_q;
      end
   end

   // One-second statistics; figures latch at the window end and hold for a second.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         winCnt_q <= 32'h00000000;
         activeAcc_q <= '0;
         waitAcc_q <= '0;
         activeNs_q <= '0;
         waitNs_q <= '0;
         txAcc_q <= 32'h00000000;
         rxAcc_q <= 32'h00000000;
         epTxUtil_q <= 32'h00000000;
         epRxUtil_q <= 32'h00000000;
      end else begin
         winCnt_q <= tick ? 32'h00000000 : winCnt_q + 32'h00000001;
         for (int c = 0; c < NCH; c++) begin
            activeAcc_q[c] <= tick ? 32'h0 : activeAcc_q[c] + (chanBusy[c] ? NS_STEP : 32'h0);
            waitAcc_q[c] <= tick ? 32'h0 : waitAcc_q[c] + (chanWait[c] ? NS_STEP : 32'h0);
            if (tick) activeNs_q[c] <= activeAcc_q[c] + (chanBusy[c] ? NS_STEP : 32'h0);
            if (tick) waitNs_q[c] <= waitAcc_q[c] + (chanWait[c] ? NS_STEP : 32'h0);
         end
         txAcc_q <= tick ? 32'h0 : txAcc_q + {31'h0, epTxBusy};
         rxAcc_q <= tick ? 32'h0 : rxAcc_q + {31'h0, epRxBusy};
         if (tick) epTxUtil_q <= txAcc_q + {31'h0, epTxBusy};
         if (tick) epRxUtil_q <= rxAcc_q + {31'h0, epRxBusy};
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_fetch_not_empty: assert property ($rose(descFetchReq_q) |->
      descFetchAddr_q == engNextPtr_q[chan_q] && engNextPtr_q[chan_q] != swNextPtr_q[chan_q])
      else $error("fetch from an empty ring");
   a_complete_ptr_adv: assert property (wbPush && !ptrWrEn |=>
      completedPtr_q[$past(chan_q)] == $past(descFetchAddr_q))
      else $error("completed pointer not advanced");
   a_wb_done_bit: assert property (wbPush |-> stat_q[`DRDMA_ST_DONE])
      else $error("writeback without completion");
   a_short_tx: assert property (state_q == ST_XFER && bufDone && isTx
      && bufCount < dLen_q |=> stat_q[`DRDMA_ST_SHORT])
      else $error("short fetch not flagged");
   a_short_rx: assert property (state_q == ST_XFER && bufDone && !isTx
      |=> !stat_q[`DRDMA_ST_SHORT])
      else $error("short flag on receive");
   a_rx_length: assert property (state_q == ST_XFER && bufDone && !isTx |=>
      stat_q[`DRDMA_ST_LEN_MSB:`DRDMA_ST_LEN_LSB] == $past(bufCount))
      else $error("receive length wrong");
   a_err_report: assert property (state_q == ST_XFER && bufDone && bufErr
      |=> stat_q[`DRDMA_ST_ERR])
      else $error("error not reported");
   a_user_ctl_hold: assert property (bufReq_q && !bufDone |=>
      bufReq_q && $stable(xferUserCtl_q))
      else $error("user control changed mid transfer");
   a_irq_enable: assert property (irqPulse_q != '0 |->
      (irqPulse_q & ~$past(intEnabled_q)) == '0)
      else $error("interrupt while disabled");
   a_wb_hold: assert property (wbValid_q && !wbReady |=> wbValid_q && $stable(wbStatus_q))
      else $error("writeback dropped under stall");

   c_short_err: cover property (wbPush && stat_q[`DRDMA_ST_SHORT]);
   c_irq_fire: cover property (irqPulse_q != '0);
   c_buf_full: cover property (wb1Valid_q && state_q == ST_WBACK);
   c_ring_wrap: cover property (wbPush && descFetchAddr_q == ringLast_q[chan_q]);
endmodule : drdma_ctrl
`default_nettype wire

//--- testbench/drdma_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// Host memory and endpoint stand-in: it answers descriptor fetches, buffer moves and writebacks.
module drdma_mem_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        slow,
   input  wire logic        wbHold,
   input  wire logic        descFetchReq_q,
   input  wire logic [31:0] descFetchAddr_q,
   input  wire logic        bufReq_q,
   output logic             descFetchAck,
   output logic [15:0]      descLen,
   output logic             descStart,
   output logic             descEnd,
   output logic             descIrq,
   output logic [7:0]       descUserCtl,
   output logic             bufDone,
   output logic [15:0]      bufCount,
   output logic             bufErr,
   output logic             bufStart,
   output logic             bufEnd,
   output logic [7:0]       bufUserStatus,
   output logic             wbReady,
   output logic             epTxBusy,
   output logic             epRxBusy
);
   logic [15:0] tLen [16];
   logic [15:0] tCnt [16];
   logic [7:0]  tUser [16];
   logic [3:0]  tFlag [16];
   logic [3:0]  cur;
   logic [2:0]  dly;
   logic [1:0]  cyc;
   logic [3:0]  fl;
   assign fl = tFlag[cur];
   // Fields are inverted outside their answer cycle, so a late sample cannot pass by luck.
   assign descLen       = descFetchAck ? tLen[cur] : ~tLen[cur];
   assign descStart     = descFetchAck ? fl[0] : ~fl[0];
   assign descEnd       = descFetchAck ? fl[1] : ~fl[1];
   assign descIrq       = descFetchAck ? fl[2] : ~fl[2];
   assign descUserCtl   = descFetchAck ? tUser[cur] : ~tUser[cur];
   assign bufCount      = bufDone ? tCnt[cur] : ~tCnt[cur];
   assign bufErr        = bufDone ? fl[3] : ~fl[3];
   assign bufStart      = bufDone ? fl[0] : ~fl[0];
   assign bufEnd        = bufDone ? fl[1] : ~fl[1];
   assign bufUserStatus = bufDone ? tUser[cur] : ~tUser[cur];
   assign wbReady       = !wbHold && (!slow || cyc[0]);
   assign epTxBusy      = cyc[0];
   assign epRxBusy      = (cyc == 2'h0);
   task automatic setDesc(input int i, input logic [15:0] len, input logic [15:0] cnt,
                          input logic [7:0] user, input logic [3:0] flg);
      tLen[i] = len;
      tCnt[i] = cnt;
      tUser[i] = user;
      tFlag[i] = flg;
   endtask : setDesc
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         descFetchAck <= 1'b0;
         bufDone <= 1'b0;
         cur <= 4'h0;
         dly <= 3'h0;
         cyc <= 2'h0;
      end else begin
         cyc <= cyc + 2'h1;
         descFetchAck <= 1'b0;
         bufDone <= 1'b0;
         if (descFetchReq_q && !descFetchAck) begin
            dly <= (dly == (slow ? 3'h4 : 3'h0)) ? 3'h0 : dly + 3'h1;
            if (dly == (slow ? 3'h4 : 3'h0)) begin
               descFetchAck <= 1'b1;
               cur <= descFetchAddr_q[8:5];
            end
         end else if (bufReq_q && !bufDone) begin
            dly <= (dly == (slow ? 3'h3 : 3'h0)) ? 3'h0 : dly + 3'h1;
            bufDone <= (dly == (slow ? 3'h3 : 3'h0));
         end
      end
   end
endmodule : drdma_mem_model
`default_nettype wire

//--- testbench/descriptor_ring_dma_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module descriptor_ring_dma_control_bench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] chanEnable = 4'h0;
   logic intEnableWr = 1'b0;
   logic [3:0] intEnableData = 4'h0;
   logic [7:0] coalesceN = 8'h00;
   logic ptrWrEn = 1'b0;
   logic [1:0] ptrWrChan = 2'h0;
   logic [2:0] ptrWrSel = 3'h0;
   logic [31:0] ptrWrData = 32'h0;
   logic slow = 1'b0;
   logic wbHold = 1'b0;
   logic descFetchAck, descStart, descEnd, descIrq, bufDone, bufErr, bufStart, bufEnd;
   logic wbReady, epTxBusy, epRxBusy, descFetchReq_q, bufReq_q, xferStart_q, xferEnd_q;
   logic wbValid_q;
   logic [15:0] descLen, bufCount, bufLen_q;
   logic [7:0] descUserCtl, bufUserStatus, xferUserCtl_q;
   logic [3:0][31:0] completedPtr_q, engNextPtr_q, swNextPtr_q, activeNs_q, waitNs_q;
   logic [3:0] intEnabled_q, irqPulse_q;
   logic [31:0] descFetchAddr_q, wbAddr_q, wbStatus_q, epTxUtil_q, epRxUtil_q;
   logic [1:0] chan_q;
   logic [63:0] wbQ [$];
   int irqCnt [4] = '{default: 0};
   int failures = 0;
   int nCompared = 0;
   always #10 clk = ~clk;
   drdma_ctrl #(.WINDOW_CYCLES(100)) dut (.clk(clk), .reset(reset), .chanEnable(chanEnable),
      .intEnableWr(intEnableWr), .intEnableData(intEnableData), .coalesceN(coalesceN),
      .ptrWrEn(ptrWrEn), .ptrWrChan(ptrWrChan), .ptrWrSel(ptrWrSel), .ptrWrData(ptrWrData),
      .descFetchAck(descFetchAck), .descLen(descLen), .descStart(descStart), .descEnd(descEnd),
      .descIrq(descIrq), .descUserCtl(descUserCtl), .bufDone(bufDone), .bufCount(bufCount),
      .bufErr(bufErr), .bufStart(bufStart), .bufEnd(bufEnd), .bufUserStatus(bufUserStatus),
      .wbReady(wbReady), .epTxBusy(epTxBusy), .epRxBusy(epRxBusy),
      .completedPtr_q(completedPtr_q), .engNextPtr_q(engNextPtr_q), .swNextPtr_q(swNextPtr_q),
      .intEnabled_q(intEnabled_q), .irqPulse_q(irqPulse_q), .descFetchReq_q(descFetchReq_q),
      .descFetchAddr_q(descFetchAddr_q), .chan_q(chan_q), .bufReq_q(bufReq_q),
      .bufLen_q(bufLen_q), .xferStart_q(xferStart_q), .xferEnd_q(xferEnd_q),
      .xferUserCtl_q(xferUserCtl_q), .wbValid_q(wbValid_q), .wbAddr_q(wbAddr_q),
      .wbStatus_q(wbStatus_q), .activeNs_q(activeNs_q), .waitNs_q(waitNs_q),
      .epTxUtil_q(epTxUtil_q), .epRxUtil_q(epRxUtil_q));
   drdma_mem_model mem (.clk(clk), .reset(reset), .slow(slow), .wbHold(wbHold),
      .descFetchReq_q(descFetchReq_q), .descFetchAddr_q(descFetchAddr_q), .bufReq_q(bufReq_q),
      .descFetchAck(descFetchAck), .descLen(descLen), .descStart(descStart), .descEnd(descEnd),
      .descIrq(descIrq), .descUserCtl(descUserCtl), .bufDone(bufDone), .bufCount(bufCount),
      .bufErr(bufErr), .bufStart(bufStart), .bufEnd(bufEnd), .bufUserStatus(bufUserStatus),
      .wbReady(wbReady), .epTxBusy(epTxBusy), .epRxBusy(epRxBusy));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      nCompared++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wrPtr(input logic [1:0] ch, input logic [2:0] sel, input logic [31:0] d);
      ptrWrEn <= 1'b1;
      ptrWrChan <= ch;
      ptrWrSel <= sel;
      ptrWrData <= d;
      @(posedge clk);
      ptrWrEn <= 1'b0;
      @(posedge clk);
   endtask : wrPtr
   task automatic setIrq(input logic [3:0] d);
      intEnableWr <= 1'b1;
      intEnableData <= d;
      @(posedge clk);
      intEnableWr <= 1'b0;
      @(posedge clk);
   endtask : setIrq
   task automatic expWb(input logic [31:0] a, input logic [31:0] s, input logic [31:0] m);
      logic [63:0] w;
      w = 64'h0;
      for (int i = 0; i < 400 && wbQ.size() == 0; i++) @(posedge clk);
      if (wbQ.size() != 0) w = wbQ.pop_front();
      chk(w[63:32], a, "writeback address");
      chk(w[31:0] & m, s, "writeback status");
   endtask : expWb
   task automatic conclude;
      $display("comparisons %0d, mismatches %0d", nCompared, failures);
      if (failures == 0 && nCompared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      if (wbValid_q === 1'b1 && wbReady === 1'b1) wbQ.push_back({wbAddr_q, wbStatus_q});
      for (int c = 0; c < 4; c++) irqCnt[c] += int'(irqPulse_q[c]);
      if (bufReq_q === 1'b1 && bufDone === 1'b1 && chan_q < 2'h2) begin
         chk({24'h0, xferUserCtl_q}, {24'h0, mem.tUser[mem.cur]}, "user control");
         chk({16'h0, bufLen_q}, {16'h0, mem.tLen[mem.cur]}, "buffer length");
         chk(32'({xferEnd_q, xferStart_q}), 32'(mem.tFlag[mem.cur][1:0]), "marks");
      end
   end
   // The budget covers all tests with slow answers; a hang beyond it is a failure.
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   initial begin
      mem.setDesc(8, 16'h0040, 16'h0040, 8'h11, 4'h1);
      mem.setDesc(9, 16'h0020, 16'h0020, 8'h22, 4'h6);
      mem.setDesc(10, 16'h0030, 16'h0014, 8'h33, 4'h3);
      mem.setDesc(11, 16'h0010, 16'h0010, 8'h44, 4'h7);
      mem.setDesc(0, 16'h0100, 16'h0064, 8'ha5, 4'h3);
      mem.setDesc(1, 16'h0100, 16'h003c, 8'h3c, 4'h9);
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      for (int c = 0; c < 4; c++) begin
         chk(completedPtr_q[c], 32'h0, "completed after reset");
         chk(engNextPtr_q[c], 32'h0, "engine next after reset");
         wrPtr(2'(c), 3'h1, 32'h1000 + 32'(c) * 32'h40);
         chk(swNextPtr_q[c], 32'h1000 + 32'(c) * 32'h40, "software next");
         wrPtr(2'(c), 3'h0, 32'h1000 + 32'(c) * 32'h40);
         chk(engNextPtr_q[c], 32'h1000 + 32'(c) * 32'h40, "engine next");
      end
      chk(swNextPtr_q[0], 32'h1000, "other rings untouched");
      setIrq(4'h5);
      chk({28'h0, intEnabled_q}, 32'h5, "interrupt enable");
      $display("test pointers and enables finished");
      wrPtr(2'h0, 3'h3, 32'h100);
      wrPtr(2'h0, 3'h4, 32'h160);
      wrPtr(2'h0, 3'h0, 32'h100);
      wrPtr(2'h0, 3'h1, 32'h100);
      wrPtr(2'h0, 3'h2, 32'hffff);
      chk(completedPtr_q[0], 32'h0, "completed cleared");
      wbHold <= 1'b1;
      chanEnable <= 4'h1;
      wrPtr(2'h0, 3'h1, 32'h160);
      repeat (100) @(posedge clk);
      chk(completedPtr_q[0], 32'h120, "third writeback held back");
      chk({31'h0, wbValid_q}, 32'h1, "writeback offered");
      wbHold <= 1'b0;
      expWb(32'h100, 32'h0040_0009, 32'hffff_ffff);
      expWb(32'h120, 32'h0020_0011, 32'hffff_ffff);
      expWb(32'h140, 32'h0014_001d, 32'hffff_ffff);
      repeat (3) @(posedge clk);
      chk(completedPtr_q[0], 32'h140, "completed advanced");
      chk(engNextPtr_q[0], 32'h160, "engine stops at software next");
      chk(32'(irqCnt[0]), 32'h1, "marked interrupt");
      setIrq(4'h4);
      slow <= 1'b1;
      wrPtr(2'h0, 3'h1, 32'h100);
      expWb(32'h160, 32'h0010_0019, 32'hffff_ffff);
      repeat (3) @(posedge clk);
      chk(engNextPtr_q[0], 32'h100, "engine next wraps");
      chk(32'(irqCnt[0]), 32'h1, "masked interrupt");
      wrPtr(2'h0, 3'h2, 32'h5a5a);
      chk(completedPtr_q[0], 32'h0, "completed clear wins");
      $display("test transmit ring finished");
      chanEnable <= 4'h0;
      coalesceN <= 8'h02;
      wrPtr(2'h2, 3'h3, 32'h200);
      wrPtr(2'h2, 3'h4, 32'h220);
      wrPtr(2'h2, 3'h0, 32'h200);
      wrPtr(2'h2, 3'h1, 32'h220);
      wrPtr(2'h2, 3'h2, 32'h0);
      chanEnable <= 4'h4;
      expWb(32'h200, 32'h0064_a519, 32'hffff_ffff);
      chk(engNextPtr_q[2], 32'h220, "receive waits at ring end");
      wrPtr(2'h2, 3'h1, 32'h200);
      expWb(32'h220, 32'h003c_3c0b, 32'hffff_ffff);
      repeat (3) @(posedge clk);
      chk(completedPtr_q[2], 32'h220, "receive completed");
      chk(engNextPtr_q[2], 32'h200, "receive wraps");
      chk(32'(irqCnt[2]), 32'h1, "coalesced interrupt");
      $display("test receive ring finished");
      chanEnable <= 4'h8;
      repeat (250) @(posedge clk);
      chk(waitNs_q[3], 32'd2000, "wait time");
      chk(activeNs_q[3], 32'h0, "active time idle");
      chk(waitNs_q[1], 32'h0, "disabled wait time");
      chk(epTxUtil_q, 32'd50, "transmit utilisation");
      chk(epRxUtil_q, 32'd25, "receive utilisation");
      $display("test statistics finished");
      conclude();
   end
endmodule : descriptor_ring_dma_control_bench
`default_nettype wire
